// ===== rtl/qed_decoder.sv
// Purpose: Quadrature A/B/index decoder with modulo counter, index latch and angle outputs.
// Assumes: AXI4-Lite slave on clk_i; encoder pins are asynchronous to clk_i.
// Notes:   Angles refresh every divider pass, about 42 clock cycles.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "qed_params.svh"

// Functional notes
// - Mode bit 0 set inverts the A input.
// - Mode bit 1 set inverts the B input.
// - Mode bit 2 set inverts the index input.
// - Bit 3 clear: index alone is the event; set: index, A and B together.
// - On index event bit 8 clear latches count; set reloads count from latch.
// - Software-writable 24-bit pulses-per-revolution sets the encoder resolution.
// - 24-bit count wraps modulo resolution; bit 12 selects negative direction.
// - Software may overwrite the step count at any time.
// - With bit 8 clear, latched index count captures the count per event and holds until the next.
// - When the index event reloads the counter, the latched count keeps its value.
// - Software may write the latched count; it reloads the count in reload mode.
// - Signed 16-bit mechanical offset sits in offset bits 15 to 0.
// - Signed 16-bit electrical offset sits in offset bits 31 to 16.
// - Mechanical angle is count * 65536 / resolution plus mechanical offset.
// - Electrical angle is mechanical angle times pole pairs plus electrical offset.
module qed_decoder
   import qed_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int CNT_W  = 24
) (
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   // Encoder pins.
   input  wire logic              enc_a_i,
   input  wire logic              enc_b_i,
   input  wire logic              enc_index_i,
   // AXI4-Lite slave.
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Angle outputs and index event pulse for the commutation logic.
   output logic [15:0]            phi_m_o,
   output logic [15:0]            phi_e_o,
   output logic                   index_event_o
);
   if (ADDR_W < 8 || CNT_W != 24) begin : g_chk
      $error("qed_decoder: address needs 8 bits and the count is 24 bits wide");
   end

   // Register state.
   logic [31:0]      mode_q;
   logic [CNT_W-1:0] ppr_q;
   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] count_n_q;
   logic [31:0]      offsets_q;
   logic [15:0]      pole_pairs_q;

   // Input synchronisers.
   wire logic [2:0] pins = {enc_index_i, enc_b_i, enc_a_i};
   logic [2:0]      sync1_q;
   logic [2:0]      sync2_q;
   logic [2:0]      prev_q;

   // Two flops per pin, then one more stage to see the previous level.
   for (genvar i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge clk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            sync1_q[i] <= 1'b0;
            sync2_q[i] <= 1'b0;
            prev_q[i]  <= 1'b0;
         end else begin
            sync1_q[i] <= pins[i];
            sync2_q[i] <= sync1_q[i];
            prev_q[i]  <= sync2_q[i];
         end
      end
   end

   // Polarity selection on the synchronised and the previous levels.
   wire logic a_cur = sync2_q[0] ^ mode_q[`QED_MODE_A_INV];
   wire logic b_cur = sync2_q[1] ^ mode_q[`QED_MODE_B_INV];
   wire logic n_cur = sync2_q[2] ^ mode_q[`QED_MODE_N_INV];
   wire logic a_old = prev_q[0] ^ mode_q[`QED_MODE_A_INV];
   wire logic b_old = prev_q[1] ^ mode_q[`QED_MODE_B_INV];
   wire logic n_old = prev_q[2] ^ mode_q[`QED_MODE_N_INV];

   // One of A and B changed is one step; a double change is dropped.
   wire logic a_chg   = a_cur ^ a_old;
   wire logic b_chg   = b_cur ^ b_old;
   wire logic step    = a_chg ^ b_chg;
   wire logic fwd     = a_cur ^ b_old;
   wire logic step_up = fwd ^ mode_q[`QED_MODE_DIR_NEG];

   // Index qualification and rising-edge detection of the qualified index.
   wire logic all3    = mode_q[`QED_MODE_ALL_THREE];
   wire logic idx_cur = n_cur & (~all3 | (a_cur & b_cur));
   wire logic idx_old = n_old & (~all3 | (a_old & b_old));
   wire logic idx_evt = idx_cur & ~idx_old;
   wire logic reload  = mode_q[`QED_MODE_RELOAD];

   // Modulo step arithmetic; a zero resolution pins the count at zero.
   wire logic [CNT_W-1:0] ppr_top  = ppr_q - 24'h00_0001;
   wire logic             at_top   = count_q >= ppr_top;
   wire logic             at_zero  = count_q == 24'h00_0000;
   wire logic [CNT_W-1:0] cnt_inc  = at_top ? 24'h00_0000 : count_q + 24'h00_0001;
   wire logic [CNT_W-1:0] cnt_dec  = at_zero ? ppr_top : count_q - 24'h00_0001;
   wire logic [CNT_W-1:0] cnt_step = (ppr_q == 24'h00_0000) ? 24'h00_0000 :
                                     (step_up ? cnt_inc : cnt_dec);

   // AXI4-Lite write path.
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   logic              aw_full_q;
   logic              w_full_q;

   wire logic aw_hs     = s_axi_awvalid & s_axi_awready;
   wire logic w_hs      = s_axi_wvalid & s_axi_wready;
   wire logic do_write  = aw_full_q & w_full_q & ~s_axi_bvalid;
   wire logic aw_full_d = ~do_write & (aw_full_q | aw_hs);
   wire logic w_full_d  = ~do_write & (w_full_q | w_hs);
   wire logic bvalid_d  = do_write | (s_axi_bvalid & ~s_axi_bready);

   // Write decode by word index.
   wire logic [5:0] widx    = awaddr_q[7:2];
   wire logic wr_mode       = do_write & (widx == `QED_IDX_MODE);
   wire logic wr_ppr        = do_write & (widx == `QED_IDX_PPR);
   wire logic wr_count      = do_write & (widx == `QED_IDX_COUNT);
   wire logic wr_count_n    = do_write & (widx == `QED_IDX_COUNT_N);
   wire logic wr_offsets    = do_write & (widx == `QED_IDX_OFFSETS);
   wire logic wr_pole_pairs = do_write & (widx == `QED_IDX_POLE_PAIRS);
   wire logic wr_hit        = (widx >= `QED_IDX_MODE) & (widx <= `QED_IDX_POLE_PAIRS);

   // Byte-lane merge of write data into an old register value.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int k = 0; k < 4; k++) begin
         if (strb[k]) begin
            res[8*k +: 8] = nw[8*k +: 8];
         end
      end
      return res;
   endfunction : merge

   // Only the defined mode bits are kept; others read zero.
   wire logic [31:0] mode_mask  = 32'h0000_110f;
   wire logic [31:0] mode_wr    = merge(mode_q, wdata_q, wstrb_q) & mode_mask;
   wire logic [31:0] ppr_wr     = merge({8'h00, ppr_q}, wdata_q, wstrb_q);
   wire logic [31:0] count_wr   = merge({8'h00, count_q}, wdata_q, wstrb_q);
   wire logic [31:0] count_n_wr = merge({8'h00, count_n_q}, wdata_q, wstrb_q);
   wire logic [31:0] offs_wr    = merge(offsets_q, wdata_q, wstrb_q);
   wire logic [31:0] pp_wr      = merge({16'h0000, pole_pairs_q}, wdata_q, wstrb_q);

   // Bus handshake state for the write channels.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         aw_full_q     <= 1'b0;
         w_full_q      <= 1'b0;
         awaddr_q      <= '0;
         wdata_q       <= 32'h0000_0000;
         wstrb_q       <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= QED_RESP_OKAY;
      end else begin
         aw_full_q     <= aw_full_d;
         w_full_q      <= w_full_d;
         s_axi_awready <= ~aw_full_d & ~bvalid_d;
         s_axi_wready  <= ~w_full_d & ~bvalid_d;
         s_axi_bvalid  <= bvalid_d;
         if (aw_hs) begin
            awaddr_q <= s_axi_awaddr;
         end
         if (w_hs) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_bresp <= wr_hit ? QED_RESP_OKAY : QED_RESP_SLVERR;
         end
      end
   end

   // Configuration registers.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_q       <= `QED_RST_MODE;
         ppr_q        <= `QED_RST_PPR;
         offsets_q    <= `QED_RST_OFFSETS;
         pole_pairs_q <= `QED_RST_POLE_PAIRS;
      end else begin
         if (wr_mode) begin
            mode_q <= mode_wr;
         end
         if (wr_ppr) begin
            ppr_q <= ppr_wr[CNT_W-1:0];
         end
         if (wr_offsets) begin
            offsets_q <= offs_wr;
         end
         if (wr_pole_pairs) begin
            pole_pairs_q <= pp_wr[15:0];
         end
      end
   end

   // Step counter and index latch.
   // A software write wins over an index event; a reload event wins over a step.
   wire logic [CNT_W-1:0] count_d =
      wr_count           ? count_wr[CNT_W-1:0] :
      (idx_evt & reload) ? count_n_q :
      step               ? cnt_step : count_q;
   wire logic [CNT_W-1:0] count_n_d =
      wr_count_n         ? count_n_wr[CNT_W-1:0] :
      (idx_evt & ~reload) ? count_q : count_n_q;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count_q       <= `QED_RST_COUNT;
         count_n_q     <= `QED_RST_COUNT;
         index_event_o <= 1'b0;
      end else begin
         count_q       <= count_d;
         count_n_q     <= count_n_d;
         index_event_o <= idx_evt;
      end
   end

   // Angle calculation.
   logic [39:0] quot;
   logic        div_done;

   qed_divider #(
      .DVD_W (`QED_DIV_STEPS),
      .DVS_W (CNT_W)
   ) u_div (
      .clk_i      (clk_i),
      .rst_n_i    (rst_n_i),
      .dividend_i ({count_q, 16'h0000}),
      .divisor_i  (ppr_q),
      .quot_o     (quot),
      .done_o     (div_done)
   );

   // Electrical angle keeps the low 16 product bits.
   wire logic [31:0] phi_prod = phi_m_o * pole_pairs_q;
   logic             e_upd_q;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phi_m_o <= 16'h0000;
         phi_e_o <= 16'h0000;
         e_upd_q <= 1'b0;
      end else begin
         e_upd_q <= div_done;
         if (div_done) begin
            phi_m_o <= quot[15:0] + offsets_q[15:0];
         end
         if (e_upd_q) begin
            phi_e_o <= phi_prod[15:0] + offsets_q[31:16];
         end
      end
   end

   // AXI4-Lite read path.
   wire logic       ar_hs    = s_axi_arvalid & s_axi_arready;
   wire logic       rvalid_d = ar_hs | (s_axi_rvalid & ~s_axi_rready);
   wire logic [5:0] ridx     = s_axi_araddr[7:2];
   wire logic       rd_hit   = (ridx >= `QED_IDX_MODE) & (ridx <= `QED_IDX_POLE_PAIRS);
   wire logic [31:0] rd_mux  =
      (ridx == `QED_IDX_MODE)       ? mode_q :
      (ridx == `QED_IDX_PPR)        ? {8'h00, ppr_q} :
      (ridx == `QED_IDX_COUNT)      ? {8'h00, count_q} :
      (ridx == `QED_IDX_COUNT_N)    ? {8'h00, count_n_q} :
      (ridx == `QED_IDX_OFFSETS)    ? offsets_q :
      (ridx == `QED_IDX_ANGLES)     ? {phi_e_o, phi_m_o} :
      (ridx == `QED_IDX_POLE_PAIRS) ? {16'h0000, pole_pairs_q} : 32'h0000_0000;

   // Read data is captured at the address handshake and held until taken.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= QED_RESP_OKAY;
      end else begin
         s_axi_arready <= ~rvalid_d;
         s_axi_rvalid  <= rvalid_d;
         if (ar_hs) begin
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? QED_RESP_OKAY : QED_RESP_SLVERR;
         end
      end
   end
endmodule : qed_decoder

// ===== rtl/qed_params.svh
// Purpose: Register indices, field positions, reset values and counts of the encoder decoder.
// Assumes: Byte address of a register is four times its index.
// Notes:   Included by the design modules and by the testbench.
`ifndef QED_PARAMS_SVH
`define QED_PARAMS_SVH

// Register indices; byte address is index * 4.
`define QED_IDX_MODE       6'h25
`define QED_IDX_PPR        6'h26
`define QED_IDX_COUNT      6'h27
`define QED_IDX_COUNT_N    6'h28
`define QED_IDX_OFFSETS    6'h29
`define QED_IDX_ANGLES     6'h2a
`define QED_IDX_POLE_PAIRS 6'h2b

// Field positions in the input configuration register.
`define QED_MODE_A_INV     0
`define QED_MODE_B_INV     1
`define QED_MODE_N_INV     2
`define QED_MODE_ALL_THREE 3
`define QED_MODE_RELOAD    8
`define QED_MODE_DIR_NEG   12

// Reset values.
`define QED_RST_MODE       32'h0000_0000
`define QED_RST_PPR        24'h00_0000
`define QED_RST_COUNT      24'h00_0000
`define QED_RST_OFFSETS    32'h0000_0000
`define QED_RST_POLE_PAIRS 16'h0001

// Divider iterations: one per dividend bit (24 count bits plus 16 fraction bits).
`define QED_DIV_STEPS      40

`endif

// ===== rtl/qed_pkg.sv
// Purpose: Types shared by the encoder decoder modules.
// Assumes: Register constants come from qed_params.svh.
// Notes:   Holds types and the AXI response code constants.
package qed_pkg;
   // Divider sequencer states, one-hot.
   typedef enum logic [2:0] {
      QED_DIV_LOAD = 3'b001,
      QED_DIV_RUN  = 3'b010,
      QED_DIV_DONE = 3'b100
   } qed_div_state_e;

   // AXI response codes.
   typedef logic [1:0] qed_resp_t;
   localparam qed_resp_t QED_RESP_OKAY   = 2'h0;
   localparam qed_resp_t QED_RESP_SLVERR = 2'h2;
endpackage : qed_pkg

// ===== rtl/qed_divider.sv
// Purpose: Free-running restoring divider producing count * 2^16 / resolution.
// Assumes: Operands may change at any time; they are sampled at the start of each pass.
// Notes:   A zero divisor yields a zero quotient.
`timescale 1ns/100ps
`include "qed_params.svh"
module qed_divider
   import qed_pkg::*;
#(
   parameter int DVD_W = 40,
   parameter int DVS_W = 24
) (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic [DVD_W-1:0] dividend_i,
   input  wire logic [DVS_W-1:0] divisor_i,
   output logic      [DVD_W-1:0] quot_o,
   output logic                  done_o
);
   if (DVD_W != `QED_DIV_STEPS || DVS_W < 1) begin : g_chk
      $error("qed_divider: dividend width must equal the iteration count");
   end

   qed_div_state_e   state_q;
   logic [DVD_W-1:0] dvd_q;
   logic [DVS_W-1:0] dvs_q;
   logic [DVS_W:0]   rem_q;
   logic [5:0]       cnt_q;

   // One restoring step: shift in the next dividend bit and try to subtract.
   wire logic [DVS_W:0] rem_sh  = {rem_q[DVS_W-1:0], dvd_q[DVD_W-1]};
   wire logic           fits    = rem_sh >= {1'b0, dvs_q};
   wire logic [DVS_W:0] rem_nx  = fits ? rem_sh - {1'b0, dvs_q} : rem_sh;
   wire logic           last    = cnt_q == 6'(`QED_DIV_STEPS - 1);

   // Sequencer: load operands, iterate, present the quotient, repeat.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= QED_DIV_LOAD;
         dvd_q   <= '0;
         dvs_q   <= '0;
         rem_q   <= '0;
         cnt_q   <= 6'h00;
         quot_o  <= '0;
         done_o  <= 1'b0;
      end else begin
         done_o <= 1'b0;
         case (state_q)
            QED_DIV_LOAD: begin
               dvd_q   <= dividend_i;
               dvs_q   <= divisor_i;
               rem_q   <= '0;
               cnt_q   <= 6'h00;
               state_q <= QED_DIV_RUN;
            end
            QED_DIV_RUN: begin
               rem_q <= rem_nx;
               dvd_q <= {dvd_q[DVD_W-2:0], fits};
               cnt_q <= cnt_q + 6'h01;
               if (last) begin
                  state_q <= QED_DIV_DONE;
               end
            end
            QED_DIV_DONE: begin
               quot_o  <= (dvs_q == '0) ? '0 : dvd_q;
               done_o  <= 1'b1;
               state_q <= QED_DIV_LOAD;
            end
            default: state_q <= QED_DIV_LOAD;
         endcase
      end
   end
endmodule : qed_divider

// ===== verification/qed_decoder_properties.sv
// Purpose: Bus handshake and index pulse checks for the encoder decoder.
// Assumes: Only the top module's ports are visible here.
// Notes:   Bound into qed_decoder below.
`timescale 1ns/100ps
module qed_decoder_properties
   import qed_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire logic        enc_index_i,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_arvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        index_event_o
);
   logic [7:0] idx_hist_q;
   logic       idx_moved;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   // Raw index pin history; an event must follow a pin edge closely.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         idx_hist_q <= '0;
      end else begin
         idx_hist_q <= {idx_hist_q[6:0], enc_index_i};
      end
   end
   assign idx_moved = |(idx_hist_q[6:1] ^ idx_hist_q[7:2]);

   // Write channel answers and holds.
   a_write_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
      else $error("write response late");
   a_write_stands: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response not held");
   a_write_release: assert property (
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
      else $error("write channel not released");
   a_write_blocked: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_resp_code: assert property (
      s_axi_bvalid |-> s_axi_bresp == QED_RESP_OKAY || s_axi_bresp == QED_RESP_SLVERR)
      else $error("bad write response code");
   // Read channel answers and holds.
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read data late");
   a_read_stands: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
         && $stable(s_axi_rresp))
      else $error("read data not held");
   a_read_release: assert property (
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read channel not released");
   // Index event pulse shape and cause.
   a_index_single: assert property (
      index_event_o |=> !index_event_o)
      else $error("index pulse too long");
   a_index_cause: assert property (
      index_event_o |-> idx_moved)
      else $error("index event without pin edge");

   c_write_refused: cover property (s_axi_bvalid && s_axi_bresp == QED_RESP_SLVERR);
   c_index_event:   cover property (index_event_o);
   c_read_done:     cover property (s_axi_rvalid && s_axi_rready);
endmodule : qed_decoder_properties

bind qed_decoder qed_decoder_properties u_props (
   .clk_i, .rst_n_i, .enc_index_i, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready,
   .s_axi_arvalid, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .index_event_o);

// ===== verification/qed_encoder_model.sv
// Purpose: Behavioural incremental encoder driving A, B and index.
// Assumes: Steps are requested by the bench through the tasks below.
// Notes:   The hold argument sets prompt or slow stepping, at least 3 cycles.
`timescale 1ns/100ps
module qed_encoder_model (
   input  wire logic clk_i,
   output logic      enc_a_o,
   output logic      enc_b_o,
   output logic      enc_index_o
);
   logic [1:0] phase_q;

   // Gray position 0..3 maps to A,B = 00, 10, 11, 01; only one line moves per step.
   initial begin
      phase_q     = 2'h0;
      enc_index_o = 1'b0;
   end
   assign enc_a_o = phase_q[1] ^ phase_q[0];
   assign enc_b_o = phase_q[1];

   // Moves one position and holds it long enough to be sampled.
   task automatic step(input logic up, input int hold);
      @(posedge clk_i);
      phase_q <= up ? phase_q + 2'h1 : phase_q - 2'h1;
      repeat (hold) @(posedge clk_i);
   endtask : step

   // Sets the index level and holds it.
   task automatic set_index(input logic lvl, input int hold);
      @(posedge clk_i);
      enc_index_o <= lvl;
      repeat (hold) @(posedge clk_i);
   endtask : set_index
endmodule : qed_encoder_model

// ===== verification/quadrature_encoder_decoder_tb.sv
// Purpose: Self-checking bench for the encoder decoder over AXI4-Lite.
// Assumes: Registers at byte address index * 4; encoder model on the pins.
// Notes:   Angle checks wait for more than two divider passes.
`timescale 1ns/100ps
`include "qed_params.svh"
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("unexpected %s: expected %h, seen %h", nm, exp, got); end end
module quadrature_encoder_decoder_tb import qed_pkg::*;;
   logic        clk_i, rst_n_i, enc_a, enc_b, enc_index, index_event_o;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [15:0] phi_m_o, phi_e_o;
   int          n_mismatch, tests_run, n_idx;
   logic [31:0] dir_mode [5] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h1000};
   logic [31:0] dir_exp [5]  = '{32'h2, 32'h3, 32'h3, 32'h2, 32'h3};
   logic [31:0] rst_exp [7]  = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1};

   qed_decoder u_dut (
      .clk_i, .rst_n_i, .enc_a_i(enc_a), .enc_b_i(enc_b), .enc_index_i(enc_index),
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .phi_m_o, .phi_e_o, .index_event_o);
   qed_encoder_model u_enc (.clk_i(clk_i), .enc_a_o(enc_a), .enc_b_o(enc_b),
      .enc_index_o(enc_index));

   // Free-running 20 MHz clock.
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   // Counts index event pulses.
   always @(posedge clk_i) begin
      if (index_event_o === 1'b1) n_idx <= n_idx + 1;
   end

   // Prints counts and verdict, then ends the run.
   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : report_and_stop

   // One write; address and data offered together, each released when taken.
   task automatic wr(input logic [5:0] idx, input logic [31:0] d, input qed_resp_t er);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge clk_i);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      s_axi_bready <= 1'b0;
      `CHK("write response", er, s_axi_bresp)
      @(posedge clk_i);
   endtask : wr

   // One read, checked against word and response.
   task automatic rd_chk(input logic [5:0] idx, input logic [31:0] ed, input qed_resp_t er);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge clk_i);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      s_axi_rready <= 1'b0;
      `CHK("read data", ed, s_axi_rdata)
      `CHK("read response", er, s_axi_rresp)
      @(posedge clk_i);
   endtask : rd_chk

   // One index pulse on the pin, then time for it to act.
   task automatic pulse;
      u_enc.set_index(1'b1, 4);
      u_enc.set_index(1'b0, 6);
   endtask : pulse

   // Watchdog well beyond the length of all tests.
   initial begin
      repeat (20000) @(posedge clk_i);
      n_mismatch++;
      report_and_stop;
   end

   // Main test sequence.
   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_arvalid, s_axi_rready, n_mismatch, tests_run, n_idx} = '0;
      s_axi_wstrb = 4'hf;
      rst_n_i = 1'b0;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      for (int i = 0; i < 7; i++) rd_chk(6'(`QED_IDX_MODE + i), rst_exp[i], QED_RESP_OKAY);
      wr(6'h30, 32'h1, QED_RESP_SLVERR);
      rd_chk(6'h30, 32'h0, QED_RESP_SLVERR);
      $display("test reset_values done");
      wr(`QED_IDX_MODE, 32'hffff_fff8, QED_RESP_OKAY);
      rd_chk(`QED_IDX_MODE, 32'h0000_1108, QED_RESP_OKAY);
      wr(`QED_IDX_MODE, 32'h0, QED_RESP_OKAY);
      wr(`QED_IDX_PPR, 32'hffff_ffff, QED_RESP_OKAY);
      rd_chk(`QED_IDX_PPR, 32'h00ff_ffff, QED_RESP_OKAY);
      wr(`QED_IDX_OFFSETS, 32'h8001_7fff, QED_RESP_OKAY);
      rd_chk(`QED_IDX_OFFSETS, 32'h8001_7fff, QED_RESP_OKAY);
      wr(`QED_IDX_ANGLES, 32'h1234_5678, QED_RESP_OKAY);
      wr(`QED_IDX_PPR, 32'h5, QED_RESP_OKAY);
      $display("test register_access done");
      for (int i = 0; i < 5; i++) begin
         wr(`QED_IDX_MODE, dir_mode[i], QED_RESP_OKAY);
         repeat (4) @(posedge clk_i);
         wr(`QED_IDX_COUNT, 32'h0, QED_RESP_OKAY);
         for (int k = 0; k < 7; k++) u_enc.step(1'b1, 3 + 5 * (i % 2));
         repeat (4) @(posedge clk_i);
         rd_chk(`QED_IDX_COUNT, dir_exp[i], QED_RESP_OKAY);
      end
      wr(`QED_IDX_MODE, 32'h0, QED_RESP_OKAY);
      $display("test count_direction done");
      wr(`QED_IDX_COUNT, 32'h3, QED_RESP_OKAY);
      pulse;
      rd_chk(`QED_IDX_COUNT_N, 32'h3, QED_RESP_OKAY);
      `CHK("index pulses", 1, n_idx)
      u_enc.set_index(1'b1, 6);
      wr(`QED_IDX_MODE, 32'h4, QED_RESP_OKAY);
      wr(`QED_IDX_COUNT, 32'h2, QED_RESP_OKAY);
      u_enc.set_index(1'b0, 6);
      rd_chk(`QED_IDX_COUNT_N, 32'h2, QED_RESP_OKAY);
      `CHK("index pulses", 3, n_idx)
      wr(`QED_IDX_MODE, 32'h8, QED_RESP_OKAY);
      wr(`QED_IDX_COUNT, 32'h1, QED_RESP_OKAY);
      pulse;
      `CHK("index pulses", 3, n_idx)
      for (int k = 0; k < 3; k++) u_enc.step(1'b1, 3);
      wr(`QED_IDX_COUNT, 32'h4, QED_RESP_OKAY);
      pulse;
      rd_chk(`QED_IDX_COUNT_N, 32'h4, QED_RESP_OKAY);
      `CHK("index pulses", 4, n_idx)
      $display("test index_latch done");
      wr(`QED_IDX_MODE, 32'h100, QED_RESP_OKAY);
      wr(`QED_IDX_COUNT_N, 32'h1, QED_RESP_OKAY);
      wr(`QED_IDX_COUNT, 32'h4, QED_RESP_OKAY);
      pulse;
      rd_chk(`QED_IDX_COUNT, 32'h1, QED_RESP_OKAY);
      wr(`QED_IDX_COUNT_N, 32'h0, QED_RESP_OKAY);
      pulse;
      rd_chk(`QED_IDX_COUNT, 32'h0, QED_RESP_OKAY);
      rd_chk(`QED_IDX_COUNT_N, 32'h0, QED_RESP_OKAY);
      $display("test index_reload done");
      wr(`QED_IDX_MODE, 32'h0, QED_RESP_OKAY);
      wr(`QED_IDX_PPR, 32'h4, QED_RESP_OKAY);
      wr(`QED_IDX_COUNT, 32'h1, QED_RESP_OKAY);
      wr(`QED_IDX_OFFSETS, 32'h0010_ff00, QED_RESP_OKAY);
      wr(`QED_IDX_POLE_PAIRS, 32'h3, QED_RESP_OKAY);
      repeat (100) @(posedge clk_i);
      rd_chk(`QED_IDX_ANGLES, 32'hbd10_3f00, QED_RESP_OKAY);
      `CHK("mechanical angle", 16'h3f00, phi_m_o)
      `CHK("electrical angle", 16'hbd10, phi_e_o)
      $display("test angles done");
      report_and_stop;
   end
endmodule : quadrature_encoder_decoder_tb
